// file: pwcd_capture.sv
// Purpose: Edge capture of the PWM command line on a 1 MHz tick
// Assumes: Command line is asynchronous to CLK
// Notes: One period result per rising edge once armed
`timescale 1ns/1ps
`default_nettype none
module pwcd_capture import pwcd_pkg::*; #(
    parameter int CNT_W = PWCD_CNT_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic pwm_in,
    output logic meas_valid,
    output logic [CNT_W-1:0] period,
    output logic [CNT_W-1:0] high_time,
    output logic overflow
);

    logic sync1_q, sync2_q, prev_q;
    logic [PWCD_DIV_W-1:0] div_q;
    logic [CNT_W-1:0] cnt_q, high_q;
    logic sense_rise_q, armed_q;

    ////////////////////////////////////////////////////////////////////////////
    // Synchroniser; only sync2 and later are looked at
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            sync1_q <= pwm_in;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    wire rise = sync2_q & ~prev_q;
    wire fall = ~sync2_q & prev_q;
    wire tick = (div_q == PWCD_DIV_W'(PWCD_TICK_DIV - 1));
    wire cap_rise = sense_rise_q & rise;
    wire cap_fall = ~sense_rise_q & fall;
    // A wrap would alias a slow period onto a short one
    wire ovf = tick & (&cnt_q);

    ////////////////////////////////////////////////////////////////////////////
    // Tick divider and period counter
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_q <= '0;
        end else if (tick) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
        end else if (ovf || cap_rise) begin
            cnt_q <= '0;
        end else if (tick) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Edge sensitivity alternates after every captured event unless an overflow forces it back to rising
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sense_rise_q <= 1'b1;
            armed_q <= 1'b0;
            high_q <= '0;
        end else begin
            if (ovf) begin
                sense_rise_q <= 1'b1;
                armed_q <= 1'b0;
            end else if (cap_rise) begin
                sense_rise_q <= 1'b0;
                armed_q <= 1'b1;
            end else if (cap_fall) begin
                sense_rise_q <= 1'b1;
            end
            if (cap_fall) begin
                high_q <= cnt_q;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meas_valid <= 1'b0;
            overflow <= 1'b0;
            period <= '0;
            high_time <= '0;
        end else begin
            meas_valid <= cap_rise & armed_q & ~ovf;
            overflow <= ovf;
            if (cap_rise) begin
                period <= cnt_q;
                high_time <= high_q;
            end
        end
    end

endmodule : pwcd_capture
`default_nettype wire

// file: pwcd_cmd_source.sv
// Purpose: Model of the control unit that drives the PWM command line
// Assumes: 20 CLK per microsecond
// Notes: New settings take effect at the next period start only
`timescale 1ns/1ps
`default_nettype none
module pwcd_cmd_source (
    input wire logic clk,
    input wire logic rst,
    input wire logic run,
    input wire logic [15:0] period_us,
    input wire logic [15:0] high_us,
    output logic pwm
);
    logic [4:0] sub_q;
    logic [15:0] us_q;
    logic [15:0] per_q;
    logic [15:0] hi_q;
    logic run_q;
    // Latching at period start keeps every period whole, so no stray short pulse
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sub_q <= 5'h00;
            us_q <= 16'h0000;
            per_q <= 16'h0020;
            hi_q <= 16'h0000;
            run_q <= 1'b0;
        end else if (sub_q != 5'h13) begin
            sub_q <= sub_q + 5'h01;
        end else begin
            sub_q <= 5'h00;
            if (us_q + 16'h0001 < per_q) begin
                us_q <= us_q + 16'h0001;
            end else begin
                us_q <= 16'h0000;
                per_q <= period_us;
                hi_q <= high_us;
                run_q <= run;
            end
        end
    end
    // One rise and one fall per period when 0 < high_us < period_us; idle line stays low when stopped
    assign #1 pwm = run_q && (us_q < hi_q);
endmodule : pwcd_cmd_source
`default_nettype wire

// file: pwcd_decoder.sv
// Purpose: Turn a PWM command line into a classified speed demand
// Assumes: 20 MHz CLK, thresholds in duty counts of 1/1024
// Notes: One evaluation per completed period, up to about 60 cycles long
//
// Summary of operation
// - Periods from 10 Hz to 1 kHz and faster are measured correctly.
// - A low-duty hysteresis band stops on/off toggling at minimum duty.
// - Duty outside the valid range may be invalid with substitute output.
// - Duty below the invalid threshold drives the invalid output value.
// - Duty below lower hysteresis, not invalid, gives the stand-by output.
// - Stand-by holds while duty rises up to the upper hysteresis.
// - Run is entered only when duty exceeds the upper hysteresis.
// - Run output interpolates linearly from minimum to maximum output.
// - Duty above the top linear level saturates at maximum output.
// - Falling in run holds minimum output until lower hysteresis.
// - Period and duty come from edges, sensitivity alternating each time.
// - A 1 MHz counter overflow is a fault that clears the measurement.
`timescale 1ns/1ps
`default_nettype none
module pwcd_decoder import pwcd_pkg::*; #(
    parameter int CNT_W = PWCD_CNT_W,
    parameter int OUT_W = PWCD_OUT_W
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic PWM_IN,
    input wire logic [PWCD_DUTY_W-1:0] INVALID_DUTY_THRESHOLD,
    input wire logic [OUT_W-1:0] INVALID_INPUT_OUTPUT_VALUE,
    input wire logic [OUT_W-1:0] LOW_STATE_OUTPUT_VALUE,
    input wire logic [PWCD_DUTY_W-1:0] HYSTERESIS_LOWER_THRESHOLD,
    input wire logic [PWCD_DUTY_W-1:0] HYSTERESIS_UPPER_THRESHOLD,
    input wire logic [OUT_W-1:0] LINEAR_OUTPUT_MINIMUM,
    input wire logic [OUT_W-1:0] LINEAR_OUTPUT_MAXIMUM,
    input wire logic [PWCD_DUTY_W-1:0] LINEAR_DUTY_TOP_LEVEL,
    input wire logic OVER_RANGE_ENABLE,
    input wire logic [PWCD_DUTY_W-1:0] OVER_RANGE_THRESHOLD,
    output logic [OUT_W-1:0] SPEED_DEMAND,
    output logic STATE_INVALID,
    output logic STATE_STANDBY,
    output logic STATE_RUN,
    output logic [PWCD_DUTY_W-1:0] MEASURED_DUTY,
    output logic [CNT_W-1:0] MEASURED_PERIOD,
    output logic UPDATE_DONE,
    output logic MEAS_FAULT
);

    localparam int REM_W = CNT_W + 1;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [PWCD_NUM_W-1:0] clamp_u(
        input logic [PWCD_NUM_W-1:0] v,
        input logic [PWCD_NUM_W-1:0] lim
    );
        clamp_u = (v > lim) ? lim : v;
    endfunction : clamp_u

    ////////////////////////////////////////////////////////////////////////////
    // Edge capture
    logic cap_valid, cap_ovf;
    logic [CNT_W-1:0] cap_period, cap_high;

    pwcd_capture #(
        .CNT_W(CNT_W)
    ) u_capture (
        .clk(CLK),
        .rst(RST),
        .pwm_in(PWM_IN),
        .meas_valid(cap_valid),
        .period(cap_period),
        .high_time(cap_high),
        .overflow(cap_ovf)
    );

    ////////////////////////////////////////////////////////////////////////////
    // State
    pwcd_proc_t proc_q;
    pwcd_cls_t cls_q;
    logic [PWCD_DUTY_W-1:0] duty_q;
    logic [CNT_W-1:0] period_q;
    logic [OUT_W-1:0] out_q;
    logic done_q, fault_q;

    logic [PWCD_DUTY_W-1:0] cfg_inv_thr_q, cfg_off_q, cfg_on_q, cfg_top_q;
    logic [PWCD_DUTY_W-1:0] cfg_ovr_thr_q;
    logic cfg_ovr_en_q;
    logic [OUT_W-1:0] cfg_inv_val_q, cfg_low_val_q, cfg_omin_q, cfg_omax_q;

    logic [PWCD_NUM_W-1:0] num_q, quo_q;
    logic [REM_W-1:0] rem_q;
    logic [CNT_W-1:0] den_q;
    logic [PWCD_IT_W-1:0] it_q;

    ////////////////////////////////////////////////////////////////////////////
    // Restoring divider, one quotient bit per cycle
    wire [REM_W-1:0] rem_sh = {rem_q[REM_W-2:0], num_q[PWCD_NUM_W-1]};
    wire div_ge = (rem_sh >= {1'b0, den_q});
    wire [REM_W-1:0] rem_nx = div_ge ? (rem_sh - {1'b0, den_q}) : rem_sh;
    wire [PWCD_NUM_W-1:0] quo_nx = {quo_q[PWCD_NUM_W-2:0], div_ge};
    wire div_last = (it_q == PWCD_IT_W'(PWCD_NUM_W - 1));

    // Duty scaled to 1/1024; a zero-tick period gives all ones, hence the clamp
    wire [PWCD_NUM_W-1:0] duty_num =
        PWCD_NUM_W'({cap_high, {PWCD_DUTY_FRAC_W{1'b0}}});
    wire [PWCD_NUM_W-1:0] duty_sat =
        clamp_u(quo_nx, PWCD_NUM_W'(PWCD_DUTY_FULL));

    ////////////////////////////////////////////////////////////////////////////
    // Classification of the latest duty
    wire below_inv = (duty_q < cfg_inv_thr_q);
    wire over_rng = cfg_ovr_en_q & (duty_q > cfg_ovr_thr_q);
    wire is_invalid = below_inv | over_rng;
    wire below_off = (duty_q < cfg_off_q);
    wire in_band = (duty_q <= cfg_on_q);
    wire at_top = (duty_q >= cfg_top_q);
    wire was_run = (cls_q == PWCD_CLS_RUN);

    pwcd_cls_t cls_new;
    logic [OUT_W-1:0] out_new;
    always_comb begin
        if (is_invalid) begin
            cls_new = PWCD_CLS_INVALID;
            out_new = cfg_inv_val_q;
        end else if (below_off) begin
            cls_new = PWCD_CLS_STANDBY;
            out_new = cfg_low_val_q;
        end else if (in_band && was_run) begin
            cls_new = PWCD_CLS_RUN;
            out_new = cfg_omin_q;
        end else if (in_band) begin
            cls_new = PWCD_CLS_STANDBY;
            out_new = cfg_low_val_q;
        end else begin
            cls_new = PWCD_CLS_RUN;
            out_new = cfg_omax_q;
        end
    end

    // Only the open part of the run region needs the second division
    wire need_lin = ~is_invalid & ~below_off & ~in_band & ~at_top;

    // Inverted limits collapse the span rather than wrap it
    wire [OUT_W-1:0] span =
        (cfg_omax_q >= cfg_omin_q) ? (cfg_omax_q - cfg_omin_q) : '0;
    wire [PWCD_DUTY_W-1:0] duty_rel = duty_q - cfg_on_q;
    wire [PWCD_DUTY_W-1:0] lin_den = cfg_top_q - cfg_on_q;
    wire [PWCD_NUM_W-1:0] lin_num =
        PWCD_NUM_W'(duty_rel) * PWCD_NUM_W'(span);
    wire [PWCD_NUM_W-1:0] lin_q = clamp_u(quo_nx, PWCD_NUM_W'(span));
    wire [OUT_W-1:0] lin_out = cfg_omin_q + lin_q[OUT_W-1:0];

    wire take_meas = (proc_q == PWCD_P_IDLE) & cap_valid;
    wire take_fault = (proc_q == PWCD_P_IDLE) & cap_ovf & ~cap_valid;

    ////////////////////////////////////////////////////////////////////////////
    // Configuration snapshot per evaluation
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            cfg_inv_thr_q <= '0;
            cfg_off_q <= '0;
            cfg_on_q <= '0;
            cfg_top_q <= '0;
            cfg_ovr_thr_q <= '0;
            cfg_ovr_en_q <= 1'b0;
            cfg_inv_val_q <= '0;
            cfg_low_val_q <= '0;
            cfg_omin_q <= '0;
            cfg_omax_q <= '0;
        end else if (take_meas || take_fault) begin
            cfg_inv_thr_q <= INVALID_DUTY_THRESHOLD;
            cfg_off_q <= HYSTERESIS_LOWER_THRESHOLD;
            cfg_on_q <= HYSTERESIS_UPPER_THRESHOLD;
            cfg_top_q <= LINEAR_DUTY_TOP_LEVEL;
            cfg_ovr_thr_q <= OVER_RANGE_THRESHOLD;
            cfg_ovr_en_q <= OVER_RANGE_ENABLE;
            cfg_inv_val_q <= INVALID_INPUT_OUTPUT_VALUE;
            cfg_low_val_q <= LOW_STATE_OUTPUT_VALUE;
            cfg_omin_q <= LINEAR_OUTPUT_MINIMUM;
            cfg_omax_q <= LINEAR_OUTPUT_MAXIMUM;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Divider registers
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            num_q <= '0;
            quo_q <= '0;
            rem_q <= '0;
            den_q <= '0;
            it_q <= '0;
        end else if (take_meas) begin
            num_q <= duty_num;
            den_q <= cap_period;
            quo_q <= '0;
            rem_q <= '0;
            it_q <= '0;
        end else if (proc_q == PWCD_P_CLS) begin
            num_q <= lin_num;
            den_q <= CNT_W'(lin_den);
            quo_q <= '0;
            rem_q <= '0;
            it_q <= '0;
        end else if (proc_q == PWCD_P_DDIV || proc_q == PWCD_P_LDIV) begin
            num_q <= {num_q[PWCD_NUM_W-2:0], 1'b0};
            quo_q <= quo_nx;
            rem_q <= rem_nx;
            it_q <= it_q + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Evaluation sequencer; nothing but an overflow fault changes between measurements
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            proc_q <= PWCD_P_IDLE;
        end else begin
            case (proc_q)
                PWCD_P_IDLE: begin
                    if (take_meas) begin
                        proc_q <= PWCD_P_DDIV;
                    end else if (take_fault) begin
                        proc_q <= PWCD_P_CLS;
                    end
                end
                PWCD_P_DDIV: begin
                    if (div_last) begin
                        proc_q <= PWCD_P_CLS;
                    end
                end
                PWCD_P_CLS: begin
                    proc_q <= need_lin ? PWCD_P_LDIV : PWCD_P_IDLE;
                end
                PWCD_P_LDIV: begin
                    if (div_last) begin
                        proc_q <= PWCD_P_IDLE;
                    end
                end
                default: begin
                    proc_q <= PWCD_P_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Measurement results
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            duty_q <= '0;
            period_q <= '0;
            fault_q <= 1'b0;
        end else begin
            fault_q <= take_fault;
            if (take_fault) begin
                duty_q <= '0;
                period_q <= '0;
            end else if (take_meas) begin
                period_q <= cap_period;
            end else if (proc_q == PWCD_P_DDIV && div_last) begin
                duty_q <= duty_sat[PWCD_DUTY_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Classified state written in the classify step, demand only at the end of an evaluation
    wire fin_cls = (proc_q == PWCD_P_CLS) & ~need_lin;
    wire fin_lin = (proc_q == PWCD_P_LDIV) & div_last;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            cls_q <= PWCD_CLS_INVALID;
            out_q <= PWCD_OUT_RST[OUT_W-1:0];
            done_q <= 1'b0;
        end else begin
            done_q <= fin_cls | fin_lin;
            if (proc_q == PWCD_P_CLS) begin
                cls_q <= cls_new;
            end
            if (fin_cls) begin
                out_q <= out_new;
            end else if (fin_lin) begin
                out_q <= lin_out;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign SPEED_DEMAND = out_q;
    assign STATE_INVALID = cls_q[0];
    assign STATE_STANDBY = cls_q[1];
    assign STATE_RUN = cls_q[2];
    assign MEASURED_DUTY = duty_q;
    assign MEASURED_PERIOD = period_q;
    assign UPDATE_DONE = done_q;
    assign MEAS_FAULT = fault_q;

endmodule : pwcd_decoder
`default_nettype wire

// file: pwcd_decoder_asserts.sv
// Purpose: Port-level checks of the PWM command decoder
// Assumes: Configuration inputs change only between evaluations
// Notes: Bound to every pwcd_decoder instance
`timescale 1ns/1ps
`default_nettype none
module pwcd_decoder_asserts import pwcd_pkg::*; #(
    parameter int CNT_W = PWCD_CNT_W,
    parameter int OUT_W = PWCD_OUT_W
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [PWCD_DUTY_W-1:0] INVALID_DUTY_THRESHOLD,
    input wire logic [OUT_W-1:0] INVALID_INPUT_OUTPUT_VALUE,
    input wire logic [OUT_W-1:0] LOW_STATE_OUTPUT_VALUE,
    input wire logic [PWCD_DUTY_W-1:0] HYSTERESIS_LOWER_THRESHOLD,
    input wire logic [PWCD_DUTY_W-1:0] HYSTERESIS_UPPER_THRESHOLD,
    input wire logic [OUT_W-1:0] LINEAR_OUTPUT_MINIMUM,
    input wire logic [OUT_W-1:0] LINEAR_OUTPUT_MAXIMUM,
    input wire logic [PWCD_DUTY_W-1:0] LINEAR_DUTY_TOP_LEVEL,
    input wire logic [OUT_W-1:0] SPEED_DEMAND,
    input wire logic STATE_INVALID,
    input wire logic STATE_STANDBY,
    input wire logic STATE_RUN,
    input wire logic [PWCD_DUTY_W-1:0] MEASURED_DUTY,
    input wire logic [CNT_W-1:0] MEASURED_PERIOD,
    input wire logic UPDATE_DONE,
    input wire logic MEAS_FAULT
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    ////////////////////////////////////////////////////////////////////////////
    // Run state of the previous update, so the band can be judged on history
    logic prev_run_q;
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) prev_run_q <= 1'b0;
        else if (UPDATE_DONE) prev_run_q <= STATE_RUN;
    end
    sequence s_done_soon;
        ##[1:3] UPDATE_DONE;
    endsequence
    sequence s_meas_cleared;
        ##[0:3] (MEASURED_DUTY == '0 && MEASURED_PERIOD == '0);
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    a_state_onehot:
    assert property ($onehot({STATE_INVALID, STATE_STANDBY, STATE_RUN})) else $error("state not one-hot");
    a_demand_then_done:
    assert property ($changed(SPEED_DEMAND) |-> UPDATE_DONE) else $error("demand moved without update");
    a_state_then_done:
    assert property ($changed({STATE_INVALID, STATE_STANDBY, STATE_RUN}) |-> ##[0:29] UPDATE_DONE)
        else $error("state moved without update");
    a_done_single:
    assert property (UPDATE_DONE |=> !UPDATE_DONE) else $error("update pulse too long");
    a_fault_clears:
    assert property (MEAS_FAULT |-> s_meas_cleared) else $error("fault left measurement");
    a_fault_reports:
    assert property (MEAS_FAULT |-> s_done_soon) else $error("fault gave no update");
    a_below_invalid:
    assert property (UPDATE_DONE && MEASURED_DUTY < INVALID_DUTY_THRESHOLD
        |-> STATE_INVALID && SPEED_DEMAND == INVALID_INPUT_OUTPUT_VALUE) else $error("low duty not invalid");
    a_low_standby:
    assert property (UPDATE_DONE && MEASURED_DUTY >= INVALID_DUTY_THRESHOLD
        && MEASURED_DUTY < HYSTERESIS_LOWER_THRESHOLD
        |-> STATE_STANDBY && SPEED_DEMAND == LOW_STATE_OUTPUT_VALUE) else $error("no stand-by");
    a_band_hold:
    assert property (UPDATE_DONE && STATE_RUN && MEASURED_DUTY <= HYSTERESIS_UPPER_THRESHOLD
        |-> prev_run_q && SPEED_DEMAND == LINEAR_OUTPUT_MINIMUM) else $error("band entered run");
    a_top_saturate:
    assert property (UPDATE_DONE && STATE_RUN && MEASURED_DUTY >= LINEAR_DUTY_TOP_LEVEL
        |-> SPEED_DEMAND == LINEAR_OUTPUT_MAXIMUM) else $error("no saturation");
    a_run_bounds:
    assert property (UPDATE_DONE && STATE_RUN |-> SPEED_DEMAND >= LINEAR_OUTPUT_MINIMUM
        && SPEED_DEMAND <= LINEAR_OUTPUT_MAXIMUM) else $error("run demand out of span");
endmodule : pwcd_decoder_asserts
bind pwcd_decoder pwcd_decoder_asserts #(.CNT_W(CNT_W), .OUT_W(OUT_W)) u_asserts (
    .CLK(CLK), .RST(RST), .INVALID_DUTY_THRESHOLD(INVALID_DUTY_THRESHOLD),
    .INVALID_INPUT_OUTPUT_VALUE(INVALID_INPUT_OUTPUT_VALUE),
    .LOW_STATE_OUTPUT_VALUE(LOW_STATE_OUTPUT_VALUE),
    .HYSTERESIS_LOWER_THRESHOLD(HYSTERESIS_LOWER_THRESHOLD),
    .HYSTERESIS_UPPER_THRESHOLD(HYSTERESIS_UPPER_THRESHOLD),
    .LINEAR_OUTPUT_MINIMUM(LINEAR_OUTPUT_MINIMUM), .LINEAR_OUTPUT_MAXIMUM(LINEAR_OUTPUT_MAXIMUM),
    .LINEAR_DUTY_TOP_LEVEL(LINEAR_DUTY_TOP_LEVEL), .SPEED_DEMAND(SPEED_DEMAND),
    .STATE_INVALID(STATE_INVALID), .STATE_STANDBY(STATE_STANDBY), .STATE_RUN(STATE_RUN),
    .MEASURED_DUTY(MEASURED_DUTY), .MEASURED_PERIOD(MEASURED_PERIOD),
    .UPDATE_DONE(UPDATE_DONE), .MEAS_FAULT(MEAS_FAULT));
`default_nettype wire

// file: pwcd_decoder_tb.sv
// Purpose: Self-checking bench of the PWM command decoder
// Assumes: Counter width cut to 10 bits so overflow comes after 1024 us
// Notes: Each case waits two updates so the new duty is surely measured
`timescale 1ns/1ps
`default_nettype none
module pwcd_decoder_tb import pwcd_pkg::*;;
    localparam int CW = 10;
    logic CLK, RST, PWM_IN, ore, run, st_inv, st_sb, st_run, done, fault;
    logic [PWCD_DUTY_W-1:0] inv_thr, low_thr, up_thr, top_lvl, ovr_thr, duty;
    logic [15:0] inv_val, low_val, lin_min, lin_max, demand, per_us, hi_us;
    logic [CW-1:0] period;
    int n_mismatch, checked;
    bit exp_run;
    pwcd_decoder #(.CNT_W(CW)) uut (.CLK(CLK), .RST(RST), .PWM_IN(PWM_IN),
        .INVALID_DUTY_THRESHOLD(inv_thr), .INVALID_INPUT_OUTPUT_VALUE(inv_val),
        .LOW_STATE_OUTPUT_VALUE(low_val), .HYSTERESIS_LOWER_THRESHOLD(low_thr),
        .HYSTERESIS_UPPER_THRESHOLD(up_thr), .LINEAR_OUTPUT_MINIMUM(lin_min),
        .LINEAR_OUTPUT_MAXIMUM(lin_max), .LINEAR_DUTY_TOP_LEVEL(top_lvl),
        .OVER_RANGE_ENABLE(ore), .OVER_RANGE_THRESHOLD(ovr_thr), .SPEED_DEMAND(demand),
        .STATE_INVALID(st_inv), .STATE_STANDBY(st_sb), .STATE_RUN(st_run),
        .MEASURED_DUTY(duty), .MEASURED_PERIOD(period), .UPDATE_DONE(done), .MEAS_FAULT(fault));
    pwcd_cmd_source src (.clk(CLK), .rst(RST), .run(run), .period_us(per_us),
        .high_us(hi_us), .pwm(PWM_IN));
    ////////////////////////////////////////////////////////////////////////////
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic wait_done(input int n);
        int lim;
        lim = 0;
        while (n > 0 && lim < 50000) begin
            @(posedge CLK);
            #2;
            lim++;
            if (done === 1'b1) n--;
        end
        cmp(n, 0);
    endtask : wait_done
    // Expected outcome from duty, thresholds and the run state held before
    task automatic run_case(input int h, input int p);
        int d;
        logic [2:0] es;
        logic [15:0] ed;
        @(posedge CLK);
        #1;
        hi_us = h;
        per_us = p;
        wait_done(2);
        d = h * 1024 / p;
        if (d > 1024) d = 1024;
        if (d < inv_thr || (ore && d > ovr_thr)) begin es = 3'b001; ed = inv_val; end
        else if (d < low_thr) begin es = 3'b010; ed = low_val; end
        else if (d <= up_thr && exp_run) begin es = 3'b100; ed = lin_min; end
        else if (d <= up_thr) begin es = 3'b010; ed = low_val; end
        else if (d >= top_lvl) begin es = 3'b100; ed = lin_max; end
        else begin es = 3'b100; ed = lin_min + (d - up_thr) * (lin_max - lin_min) / (top_lvl - up_thr); end
        exp_run = es[2];
        cmp(duty, d);
        cmp(period, p);
        cmp({st_run, st_sb, st_inv}, es);
        cmp(demand, ed);
    endtask : run_case
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_invalid_output;
        run_case(1, 32);
        @(posedge CLK);
        #1;
        inv_val = 16'h0000;
        run_case(1, 32);
    endtask : t_invalid_output
    task automatic t_standby_band;
        run_case(2, 32);
        run_case(4, 32);
        run_case(6, 32);
        run_case(7, 32);
    endtask : t_standby_band
    task automatic t_run_linear;
        run_case(8, 32);
        run_case(10, 32);
        run_case(28, 32);
        run_case(29, 32);
        run_case(31, 32);
    endtask : t_run_linear
    task automatic t_fall_hold;
        run_case(20, 32);
        run_case(7, 32);
        run_case(6, 32);
        run_case(4, 32);
        run_case(6, 32);
    endtask : t_fall_hold
    task automatic t_slow_command;
        run_case(500, 1000);
    endtask : t_slow_command
    // Line stuck low: counter wraps, measurement cleared, then re-arms
    task automatic t_overflow_fault;
        int lim;
        @(posedge CLK);
        #1;
        run = 1'b0;
        per_us = 32;
        hi_us = 10;
        lim = 0;
        while (fault !== 1'b1 && lim < 30000) begin
            @(posedge CLK);
            #2;
            lim++;
        end
        cmp(fault, 1'b1);
        wait_done(1);
        cmp({duty, period}, '0);
        cmp({st_run, st_sb, st_inv, demand}, {3'b001, inv_val});
        exp_run = 1'b0;
        @(posedge CLK);
        #1;
        run = 1'b1;
        run_case(10, 32);
    endtask : t_overflow_fault
    task automatic conclude;
        if (n_mismatch == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : conclude
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        CLK = 1'b0;
        forever #25 CLK = ~CLK;
    end
    initial begin
        #5_000_000;
        n_mismatch++;
        conclude();
    end
    initial begin
        n_mismatch = 0;
        checked = 0;
        exp_run = 1'b0;
        RST = 1'b1;
        run = 1'b0;
        ore = 1'b1;
        per_us = 32;
        hi_us = 1;
        inv_thr = 11'h040;
        low_thr = 11'h0a0;
        up_thr = 11'h0e0;
        top_lvl = 11'h380;
        ovr_thr = 11'h3c0;
        inv_val = 16'hffff;
        low_val = 16'h0000;
        lin_min = 16'h0100;
        lin_max = 16'h1000;
        repeat (5) @(posedge CLK);
        #1;
        RST = 1'b0;
        run = 1'b1;
        t_invalid_output();
        t_standby_band();
        t_run_linear();
        t_fall_hold();
        t_slow_command();
        t_overflow_fault();
        conclude();
    end
endmodule : pwcd_decoder_tb
`default_nettype wire

// file: pwcd_pkg.sv
// Purpose: Shared constants and types of the PWM command decoder
// Assumes: 20 MHz system clock, 1 MHz measurement tick
// Notes: Duty is a binary fraction, 1024 counts meaning 100 percent
package pwcd_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int PWCD_CLK_HZ = 20_000_000;
    localparam int PWCD_TICK_HZ = 1_000_000;
    localparam int PWCD_TICK_DIV = PWCD_CLK_HZ / PWCD_TICK_HZ;
    localparam int PWCD_DIV_W = $clog2(PWCD_TICK_DIV);
    localparam int PWCD_MIN_CMD_HZ = 10;
    localparam int PWCD_MAX_CMD_HZ = 1000;
    // Longest period in ticks must fit the counter without wrapping
    localparam int PWCD_MAX_PERIOD_TICKS = PWCD_TICK_HZ / PWCD_MIN_CMD_HZ;
    localparam int PWCD_CNT_W = $clog2(PWCD_MAX_PERIOD_TICKS + 1);

    ////////////////////////////////////////////////////////////////////////////
    // Duty scaling and datapath widths
    localparam int PWCD_DUTY_FRAC_W = 10;
    localparam int PWCD_DUTY_W = PWCD_DUTY_FRAC_W + 1;
    localparam logic [10:0] PWCD_DUTY_FULL = 11'h400;
    localparam int PWCD_OUT_W = 16;
    localparam int PWCD_NUM_W = 28;
    localparam int PWCD_IT_W = 5;
    localparam logic [15:0] PWCD_OUT_RST = 16'h0000;

    ////////////////////////////////////////////////////////////////////////////
    // Classified command state
    typedef enum logic [2:0] {
        PWCD_CLS_INVALID = 3'b001,
        PWCD_CLS_STANDBY = 3'b010,
        PWCD_CLS_RUN = 3'b100
    } pwcd_cls_t;

    // Evaluation sequencer
    typedef enum logic [3:0] {
        PWCD_P_IDLE = 4'b0001,
        PWCD_P_DDIV = 4'b0010,
        PWCD_P_CLS = 4'b0100,
        PWCD_P_LDIV = 4'b1000
    } pwcd_proc_t;

endpackage : pwcd_pkg
